// ===== hw/fanout_pkg.sv
// constants and carrier types for the two-bank gated clock fan-out
// assumes one system clock fast enough to oversample the reference clock pin
// How it works
// [R1] one input clock copied to two banks of five
// [R2] all outputs low after reset until enabled
// [R3] enable low at falling edge forces bank low
// [R4] enable high at falling edge passes clock
// [R5] gate changes only while clock low, no runts
// [R6] bank a enable active high, no inversion
// [R7] bank b gated only by its own enable
// [R8] enables captured at falling edge, gates reset cleared
`default_nettype none
package fanout_pkg;

  // ----------------------------------------------------------------
  // sizes and reset values
  // ----------------------------------------------------------------
  localparam int BANK_OUTPUTS = 5;
  localparam int BANK_COUNT = 2;
  localparam int SYNC_STAGES = 3;
  localparam logic GATE_RESET = 1'h0;
  localparam logic LEVEL_RESET = 1'h0;

  // ----------------------------------------------------------------
  // pin samples after synchronising
  // ----------------------------------------------------------------
  typedef struct packed {
    logic ref_clk;
    logic bank_a_enable;
    logic bank_b_enable;
  } pin_sample_type;

endpackage
`default_nettype wire

// ===== hw/pin_sync.sv
// three-stage synchroniser with agreement filter for slow pins
// assumes inputs are asynchronous to clk
`timescale 1ns/10ps
`default_nettype none
module pin_sync
  import fanout_pkg::*;
#(
  parameter int WIDTH = 3
)
(
  input wire logic clk, // system clock
  input wire logic sys_rst, // async reset, active high
  input wire logic [WIDTH-1:0] pin_in, // raw pins
  output logic [WIDTH-1:0] level_out // filtered level
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] level;
  } sync_state_type;

  sync_state_type st_r;
  sync_state_type st_nxt;

  // ----------------------------------------------------------------
  // stages
  // ----------------------------------------------------------------
  // s1 feeds only s2; a bit only counts once s2 and s3 agree
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.s1 = pin_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (st_r.s2[i] == st_r.s3[i])
      begin
        st_nxt.level[i] = st_r.s3[i];
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign level_out = st_r.level;

endmodule
`default_nettype wire

// ===== hw/clock_fanout.sv
// two-bank clock fan-out with glitch-free gating at falling edges
// assumes ref_clk_in is well below half of clk so its edges are seen
// limitation: output edges land on the clk grid, so duty is only as fine as one clk
`timescale 1ns/10ps
`default_nettype none
module clock_fanout
  import fanout_pkg::*;
#(
  parameter int NOUT = BANK_OUTPUTS
)
(
  input wire logic clk, // system clock, 125 MHz
  input wire logic sys_rst, // async reset, active high
  input wire logic ref_clk_in, // clock to distribute
  input wire logic bank_a_enable, // bank a enable, active high
  input wire logic bank_b_enable, // bank b enable, active high
  output logic [NOUT-1:0] bank_a_outputs, // bank a clock copies
  output logic [NOUT-1:0] bank_b_outputs // bank b clock copies
);

  typedef struct packed {
    logic prev_clk;
    logic gate_a;
    logic gate_b;
    logic [NOUT-1:0] out_a;
    logic [NOUT-1:0] out_b;
  } fan_state_type;

  fan_state_type st_r;
  fan_state_type st_nxt;
  pin_sample_type pins;
  logic fall;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // the clock goes through the same filter as the enables, so an enable
  // and the edge that captures it see the same latency
  pin_sync #(
    .WIDTH($bits(pin_sample_type))
  ) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin_in({ref_clk_in, bank_a_enable, bank_b_enable}),
    .level_out(pins)
  );

  // ----------------------------------------------------------------
  // gating
  // ----------------------------------------------------------------
  // edges are judged on the filtered level: about four clk of latency,
  // traded for a pin that cannot fake an edge with a single bad sample
  assign fall = st_r.prev_clk & ~pins.ref_clk;

  // gates move only at a falling edge, when the clock is low, so the
  // outputs never start or stop in the middle of a high phase
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.prev_clk = pins.ref_clk;
    if (fall) // R8
    begin
      st_nxt.gate_a = pins.bank_a_enable; // R3 R4 R6
      st_nxt.gate_b = pins.bank_b_enable; // R7
    end
    // outputs use the fresh gate, so a bank shut at this fall is low in
    // the same cycle; the clock is low here anyway, which is why a gate
    // change can never shorten a high phase
    st_nxt.out_a = {NOUT{st_nxt.gate_a & pins.ref_clk}}; // R1 R5
    st_nxt.out_b = {NOUT{st_nxt.gate_b & pins.ref_clk}}; // R1 R5
  end

  // prev_clk resets low so a pin high at release is not a falling edge
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_r.prev_clk <= LEVEL_RESET;
      st_r.gate_a <= GATE_RESET; // R2 R8
      st_r.gate_b <= GATE_RESET; // R2 R8
      st_r.out_a <= '0;
      st_r.out_b <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign bank_a_outputs = st_r.out_a;
  assign bank_b_outputs = st_r.out_b;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // every check runs on clk and sleeps through reset; the relations
  // below rest on out(t) = gate(t) & ref(t-1), as both registers load together
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // ----------------------------------------------------------------
  // checks: reset and copies
  // ----------------------------------------------------------------
  fanout_copies_a: assert property ( // R1
    (bank_a_outputs == {NOUT{bank_a_outputs[0]}})
    && (bank_b_outputs == {NOUT{bank_b_outputs[0]}}))
    else $error("bank copies differ");

  banks_agree_a: assert property ( // R1
    st_r.gate_a && st_r.gate_b |-> bank_a_outputs == bank_b_outputs)
    else $error("enabled banks disagree");

  // nothing may leave the block before a gate has been opened at a fall
  reset_quiet_a: assert property ( // R2
    $past(sys_rst) |-> bank_a_outputs == '0 && bank_b_outputs == '0)
    else $error("outputs not low after reset");

  startup_low_a: assert property ( // R2
    !st_r.gate_a |-> bank_a_outputs == '0)
    else $error("bank a high while gated");

  idle_b_low_a: assert property ( // R2
    !st_r.gate_b |-> bank_b_outputs == '0)
    else $error("bank b high while gated");

  // a copy is only ever high while the clock it copies was high
  ref_low_quiet_a: assert property ( // R5
    !$past(pins.ref_clk) |-> bank_a_outputs == '0 && bank_b_outputs == '0)
    else $error("output high while clock low");

  // ----------------------------------------------------------------
  // checks: bank a
  // ----------------------------------------------------------------
  disable_low_a: assert property ( // R3
    fall && !pins.bank_a_enable |=> (!st_r.gate_a && bank_a_outputs == '0) [*2])
    else $error("bank a not forced low");

  bank_a_on_a: assert property ( // R4
    fall && pins.bank_a_enable |=> st_r.gate_a)
    else $error("bank a not enabled at fall");

  follow_a_a: assert property ( // R6
    st_r.gate_a |-> bank_a_outputs[0] == $past(pins.ref_clk))
    else $error("bank a not following clock");

  // a high phase may only begin with the clock's own rise and end with its
  // own fall; a gate that cut in mid-phase would trip one of these two
  a_starts_whole_a: assert property ( // R5
    $rose(bank_a_outputs[0]) |-> $past(pins.ref_clk) && !$past(pins.ref_clk, 2))
    else $error("bank a started a short high phase");

  a_ends_whole_a: assert property ( // R5
    $fell(bank_a_outputs[0]) |-> !$past(pins.ref_clk))
    else $error("bank a cut a high phase");

  // ----------------------------------------------------------------
  // checks: bank b
  // ----------------------------------------------------------------
  // bank b mirrors bank a and must not care about bank a's enable
  bank_b_off_a: assert property ( // R3
    fall && !pins.bank_b_enable |=> (!st_r.gate_b && bank_b_outputs == '0) [*2])
    else $error("bank b not forced low");

  enable_pass_a: assert property ( // R4
    fall && pins.bank_b_enable |=> st_r.gate_b)
    else $error("bank b not enabled at fall");

  follow_b_a: assert property ( // R7
    st_r.gate_b |-> bank_b_outputs[0] == $past(pins.ref_clk))
    else $error("bank b not following clock");

  b_starts_whole_a: assert property ( // R5
    $rose(bank_b_outputs[0]) |-> $past(pins.ref_clk) && !$past(pins.ref_clk, 2))
    else $error("bank b started a short high phase");

  b_ends_whole_a: assert property ( // R5
    $fell(bank_b_outputs[0]) |-> !$past(pins.ref_clk))
    else $error("bank b cut a high phase");

  // ----------------------------------------------------------------
  // checks: gate capture
  // ----------------------------------------------------------------
  // gates move one cycle after a detected fall, to the enable seen there
  no_runt_a: assert property ( // R5
    $changed(st_r.gate_a) || $changed(st_r.gate_b)
    |-> bank_a_outputs[0] == 1'h0 && bank_b_outputs[0] == 1'h0)
    else $error("gate changed with clock high");

  capture_fall_a: assert property ( // R8
    $changed(st_r.gate_a) || $changed(st_r.gate_b) |-> $past(fall))
    else $error("gate moved outside falling edge");

  capture_value_a: assert property ( // R8
    fall |=> st_r.gate_a == $past(pins.bank_a_enable)
    && st_r.gate_b == $past(pins.bank_b_enable))
    else $error("gate differs from captured enable");

  bank_split_a: assert property ( // R7
    fall && pins.bank_b_enable && !pins.bank_a_enable |=> st_r.gate_b && !st_r.gate_a)
    else $error("bank b gate tied to bank a");

  split_other_a: assert property ( // R7
    fall && pins.bank_a_enable && !pins.bank_b_enable |=> st_r.gate_a && !st_r.gate_b)
    else $error("bank a gate tied to bank b");

  // enable moves between falls must leave the gates alone; that is what
  // keeps a bank from opening halfway through a high phase
  gate_a_hold_a: assert property ( // R5
    !fall |=> $stable(st_r.gate_a))
    else $error("bank a gate moved between falls");

  gate_b_hold_a: assert property ( // R5
    !fall |=> $stable(st_r.gate_b))
    else $error("bank b gate moved between falls");

  // ----------------------------------------------------------------
  // coverage
  // ----------------------------------------------------------------
  // the scenarios the bench is meant to reach
  enable_a_c: cover property (fall && pins.bank_a_enable && !st_r.gate_a);
  disable_b_c: cover property (fall && !pins.bank_b_enable && st_r.gate_b);
  split_c: cover property (st_r.gate_a && !st_r.gate_b && bank_a_outputs[0]);
  disable_a_c: cover property (fall && !pins.bank_a_enable && st_r.gate_a);
  both_on_c: cover property (st_r.gate_a && st_r.gate_b && bank_b_outputs[0]);

endmodule
`default_nettype wire

// ===== verification/ref_source.sv
// free-running source model for the reference clock pin
// assumes clk is the bench clock; run low keeps the source quiet
`timescale 1ns/10ps
`default_nettype none
module ref_source #(parameter int HALF = 16)
(
  input wire logic clk, // bench clock
  input wire logic run, // source enable
  output logic ref_clk_out // reference clock
);
  int cnt = 0;
  initial ref_clk_out = 1'h0;
  // offset from clk, since a board oscillator is not aligned to it
  always @(negedge clk)
  begin
    if (run)
    begin
      cnt = cnt + 1;
      if (cnt >= HALF)
      begin
        cnt = 0;
        ref_clk_out <= #1 ~ref_clk_out;
      end
    end
  end
endmodule
`default_nettype wire

// ===== verification/testbench.sv
// self-checking bench for the two-bank gated clock fan-out
// assumes ref_source drives the reference pin; enables move at clk falls
`timescale 1ns/10ps
`default_nettype none
module testbench
  import fanout_pkg::*;
;
  logic clk, sys_rst, ref_clk, run, en_a, en_b;
  logic [BANK_OUTPUTS-1:0] out_a, out_b;
  logic [2*BANK_OUTPUTS-1:0] notes[$];
  logic [2*BANK_OUTPUTS-1:0] gate, exp_v;
  int miscompares, n_checks, seed, i;
  clock_fanout DUT (.clk(clk), .sys_rst(sys_rst), .ref_clk_in(ref_clk),
    .bank_a_enable(en_a), .bank_b_enable(en_b),
    .bank_a_outputs(out_a), .bank_b_outputs(out_b));
  ref_source #(.HALF(16)) src (.clk(clk), .run(run), .ref_clk_out(ref_clk));
  initial
  begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wait_ref(input logic lvl);
    int k;
    k = 0;
    while (ref_clk !== lvl && k < 100)
    begin
      @(posedge clk);
      k++;
    end
    if (k >= 100)
    begin
      miscompares++;
      $display("timeout at %0t waiting for reference level %h", $time, lvl);
      wrap_up();
    end
  endtask
  // -------------------------------------------------------------
  // monitor: sample mid-phase, well past the pin-to-output delay
  // -------------------------------------------------------------
  always @(ref_clk)
  begin
    repeat (10) @(posedge clk);
    #1;
    if (notes.size() > 0)
    begin
      exp_v = notes.pop_front();
      n_checks++;
      if ({out_a, out_b} !== exp_v)
      begin
        miscompares++;
        $display("wrong value at %0t: got %h expected %h", $time, {out_a, out_b}, exp_v);
      end
    end
  end
  // -------------------------------------------------------------
  // stimulus: enables move during the high phase, so each high
  // phase must still show the gate taken at the previous fall
  // -------------------------------------------------------------
  initial
  begin
    seed = 59723;
    miscompares = 0;
    n_checks = 0;
    sys_rst = 1'h1;
    run = 1'h0;
    en_a = 1'h1;
    en_b = 1'h1;
    gate = '0;
    repeat (12) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'h0;
    run = 1'h1;
    for (i = 0; i < 40; i++)
    begin
      wait_ref(1'h0);
      wait_ref(1'h1);
      notes.push_back(gate);
      notes.push_back('0);
      @(negedge clk);
      en_a = 1'($random(seed));
      en_b = 1'($random(seed));
      gate = {{BANK_OUTPUTS{en_a}}, {BANK_OUTPUTS{en_b}}};
    end
    repeat (40) @(posedge clk);
    if (notes.size() != 0)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h notes left, expected %h", $time, notes.size(), 0);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
